// *** elp_pkg.sv ***
// Purpose: Shared constants and types for the encoder limit and PID block
// Assumes: 32-bit Avalon-MM register words, byte addresses
// Notes: Action byte holds motor selection in [7:4] and action code in [3:0]
package elp_pkg;
    // ********************************
    // Register byte offsets
    // ********************************
    localparam logic [6:0] OFS_CTRL = 7'h00;
    localparam logic [6:0] OFS_HIGH_LIMIT = 7'h04;
    localparam logic [6:0] OFS_LOW_LIMIT = 7'h08;
    localparam logic [6:0] OFS_HOME = 7'h0C;
    localparam logic [6:0] OFS_HIGH_ACTION = 7'h10;
    localparam logic [6:0] OFS_LOW_ACTION = 7'h14;
    localparam logic [6:0] OFS_USAGE = 7'h18;
    localparam logic [6:0] OFS_PULSES = 7'h1C;
    localparam logic [6:0] OFS_INT_CAP = 7'h20;
    localparam logic [6:0] OFS_PROP_GAIN = 7'h24;
    localparam logic [6:0] OFS_INT_GAIN = 7'h28;
    localparam logic [6:0] OFS_DIFF_GAIN = 7'h2C;
    localparam logic [6:0] OFS_POS_CMD = 7'h30;
    localparam logic [6:0] OFS_COUNT = 7'h34;
    localparam logic [6:0] OFS_LOOP_OUT = 7'h38;
    localparam logic [6:0] OFS_STATUS = 7'h3C;
    localparam logic [6:0] OFS_MASK = 7'h40;
    localparam logic [6:0] OFS_SPEED = 7'h44;
    // ********************************
    // Control and status bits
    // ********************************
    localparam int CTRL_LOOP_EN = 0;
    localparam int CTRL_HOME_CMD = 1;
    localparam int CTRL_REL_MODE = 2;
    localparam int CTRL_BL_TORQUE = 3;
    localparam int ST_HIGH = 0;
    localparam int ST_LOW = 1;
    localparam int ST_HOME = 2;
    localparam int ST_W = 3;
    // ********************************
    // Reset values and ranges
    // ********************************
    localparam logic [31:0] RST_HIGH_LIMIT = 32'h00004E20;
    localparam logic [31:0] RST_LOW_LIMIT = 32'hFFFFB1E0;
    localparam logic [15:0] RST_PULSES = 16'h0064;
    localparam logic [7:0] CAP_MIN = 8'h01;
    localparam logic [7:0] CAP_MAX = 8'h64;
    localparam logic [31:0] GAIN_MAX = 32'h77359400;
    localparam logic [63:0] GAIN_SCALE = 64'h00000000000F4240;
    localparam logic [63:0] REL_SPAN = 64'h00000000000007D0;
    localparam logic [63:0] REL_HALF = 64'h00000000000003E8;
    localparam logic [3:0] ACT_HOME = 4'h8;
    localparam int ACT_MOT_LSB = 4;
    // ********************************
    // Types
    // ********************************
    typedef enum logic [3:0] {
        ELP_ACT_NONE = 4'h0, ELP_ACT_SAFETY = 4'h1, ELP_ACT_ESTOP = 4'h2,
        ELP_ACT_MSTOP = 4'h3, ELP_ACT_FWD = 4'h4, ELP_ACT_REV = 4'h5,
        ELP_ACT_INV = 4'h6, ELP_ACT_SCRIPT = 4'h7, ELP_ACT_LOAD = 4'h8
    } elp_act_t;
    typedef struct packed {
        logic valid;
        logic [3:0] motors;
        logic [3:0] code;
    } elp_action_t;
endpackage

// *** elp_core.sv ***
// Purpose: Quadrature counter with soft limits, home load and PID loop
// Assumes: 25 MHz sys_clk_in, encoder and home pins asynchronous
// Notes: Registers on Avalon-MM, one wait state per access
//
// Summary of operation
// - Counter above high limit issues the configured high-limit action code 1..8; code 0 issues nothing.
// - Action byte carries motor selection 16, 32, 48 above the code.
// - Counter below low limit issues the low-limit action, same encoding.
// - Home value loads counter on home switch, host command or script request.
// - Low trigger when counter below signed low limit, default -20000.
// - High trigger above high limit, default 20000; relative +1000 targets it.
// - Relative command -1000 targets the low limit; limits span the travel.
// - Encoder usage: 0 unused, 1 command, 2 feedback, plus motor term.
// - Four counts per encoder pulse.
// - Negative pulses per revolution inverts count and speed polarity.
// - Integral term clamped to cap percentage 1..100, default 100.
// - Gains unsigned 32-bit, times one million, 0..2e9, default 0.
// - Gains used in all closed-loop modes; brushless torque mode bypasses them.
`timescale 1ns/1ns
`default_nettype none
module elp_core #(
    parameter int LOOP_DIV = 250,
    parameter logic [31:0] INT_FULL = 32'h3B9ACA00
) (
    input wire logic sys_clk_in,
    input wire logic arst_n_in,
    input wire logic [6:0] address_in,
    input wire logic read_in,
    input wire logic write_in,
    input wire logic [31:0] writedata_in,
    output logic [31:0] readdata_out,
    output logic waitrequest_out,
    input wire logic enc_a_in,
    input wire logic enc_b_in,
    input wire logic home_sw_in,
    input wire logic script_home_in,
    output elp_pkg::elp_action_t action_out,
    output logic [7:0] usage_out,
    output logic [31:0] loop_out,
    output logic irq_out
);
    import elp_pkg::*;

    // ********************************
    // Configuration registers
    // ********************************
    logic [31:0] ctrl, high_count_limit, low_count_limit, home_load_value, pos_cmd;
    logic [7:0] high_limit_action, low_limit_action, encoder_usage, integral_cap;
    logic [15:0] pulses_per_rev;
    logic [31:0] proportional_gain, integral_gain, differential_gain;
    logic [ST_W-1:0] status, mask;
    logic ack, wr_go, home_cmd;
    logic [31:0] count, speed, last_count;

    // Clamp a gain write into the legal range
    function automatic logic [31:0] gain_clip(input logic [31:0] v);
        return (v > GAIN_MAX) ? GAIN_MAX : v;
    endfunction

    // One wait state lets read data come from a flop
    assign waitrequest_out = (read_in | write_in) & ~ack;
    assign wr_go = write_in & ack;
    assign home_cmd = wr_go && address_in == OFS_CTRL && writedata_in[CTRL_HOME_CMD];

    // Bus acknowledge and read data
    always_ff @(posedge sys_clk_in or negedge arst_n_in) begin
        if (!arst_n_in) begin
            ack <= 1'b0;
            readdata_out <= 32'h00000000;
        end else begin
            ack <= (read_in | write_in) & ~ack;
            if (read_in & ~ack) begin
                case (address_in)
                    OFS_CTRL: readdata_out <= ctrl;
                    OFS_HIGH_LIMIT: readdata_out <= high_count_limit;
                    OFS_LOW_LIMIT: readdata_out <= low_count_limit;
                    OFS_HOME: readdata_out <= home_load_value;
                    OFS_HIGH_ACTION: readdata_out <= {24'h000000, high_limit_action};
                    OFS_LOW_ACTION: readdata_out <= {24'h000000, low_limit_action};
                    OFS_USAGE: readdata_out <= {24'h000000, encoder_usage};
                    OFS_PULSES: readdata_out <= {{16{pulses_per_rev[15]}}, pulses_per_rev};
                    OFS_INT_CAP: readdata_out <= {24'h000000, integral_cap};
                    OFS_PROP_GAIN: readdata_out <= proportional_gain;
                    OFS_INT_GAIN: readdata_out <= integral_gain;
                    OFS_DIFF_GAIN: readdata_out <= differential_gain;
                    OFS_POS_CMD: readdata_out <= pos_cmd;
                    OFS_COUNT: readdata_out <= count;
                    OFS_LOOP_OUT: readdata_out <= loop_out;
                    OFS_STATUS: readdata_out <= {29'h00000000, status};
                    OFS_MASK: readdata_out <= {29'h00000000, mask};
                    OFS_SPEED: readdata_out <= speed;
                    default: readdata_out <= 32'h00000000;
                endcase
            end
        end
    end

    // Register writes; home command bit is a self-clearing strobe
    always_ff @(posedge sys_clk_in or negedge arst_n_in) begin
        if (!arst_n_in) begin
            ctrl <= 32'h00000000;
            high_count_limit <= RST_HIGH_LIMIT;
            low_count_limit <= RST_LOW_LIMIT;
            home_load_value <= 32'h00000000;
            high_limit_action <= 8'h00;
            low_limit_action <= 8'h00;
            encoder_usage <= 8'h00;
            pulses_per_rev <= RST_PULSES;
            integral_cap <= CAP_MAX;
            proportional_gain <= 32'h00000000;
            integral_gain <= 32'h00000000;
            differential_gain <= 32'h00000000;
            pos_cmd <= 32'h00000000;
            mask <= '0;
        end else if (wr_go) begin
            case (address_in)
                OFS_CTRL: ctrl <= writedata_in & ~(32'h00000001 << CTRL_HOME_CMD);
                OFS_HIGH_LIMIT: high_count_limit <= writedata_in;
                OFS_LOW_LIMIT: low_count_limit <= writedata_in;
                OFS_HOME: home_load_value <= writedata_in;
                OFS_HIGH_ACTION: high_limit_action <= writedata_in[7:0];
                OFS_LOW_ACTION: low_limit_action <= writedata_in[7:0];
                OFS_USAGE: encoder_usage <= writedata_in[7:0];
                OFS_PULSES: pulses_per_rev <= writedata_in[15:0];
                OFS_INT_CAP: begin
                    // Full word tested first so large values do not wrap to the low end
                    if (writedata_in > 32'(CAP_MAX)) begin
                        integral_cap <= CAP_MAX;
                    end else if (writedata_in[7:0] < CAP_MIN) begin
                        integral_cap <= CAP_MIN;
                    end else begin
                        integral_cap <= writedata_in[7:0];
                    end
                end
                OFS_PROP_GAIN: proportional_gain <= gain_clip(writedata_in);
                OFS_INT_GAIN: integral_gain <= gain_clip(writedata_in);
                OFS_DIFF_GAIN: differential_gain <= gain_clip(writedata_in);
                OFS_POS_CMD: pos_cmd <= writedata_in;
                OFS_MASK: mask <= writedata_in[ST_W-1:0];
                default: ;
            endcase
        end
    end
    assign usage_out = encoder_usage;

    // ********************************
    // Pin synchronisers and quadrature decode
    // ********************************
    logic [2:0] sync1, sync2, prev;
    always_ff @(posedge sys_clk_in or negedge arst_n_in) begin
        if (!arst_n_in) begin
            sync1 <= 3'h0;
            sync2 <= 3'h0;
            prev <= 3'h0;
        end else begin
            sync1 <= {home_sw_in, enc_b_in, enc_a_in};
            sync2 <= sync1;
            prev <= sync2;
        end
    end

    // Every edge of either phase counts, giving four counts per pulse
    logic step, up, home_sw_rise, home_evt, hi_cond, lo_cond, hi_prev, lo_prev;
    logic hi_rise, lo_rise;
    assign step = (sync2[0] ^ prev[0]) | (sync2[1] ^ prev[1]);
    assign up = (sync2[0] ^ prev[1]) ^ pulses_per_rev[15];
    assign home_sw_rise = sync2[2] & ~prev[2];
    assign hi_cond = $signed(count) > $signed(high_count_limit);
    assign lo_cond = $signed(count) < $signed(low_count_limit);
    assign hi_rise = hi_cond & ~hi_prev;
    assign lo_rise = lo_cond & ~lo_prev;
    // Limit action code 8 reloads the home value
    assign home_evt = home_sw_rise | home_cmd | script_home_in
        | (hi_rise && high_limit_action[3:0] == ACT_HOME)
        | (lo_rise && low_limit_action[3:0] == ACT_HOME);

    // Counter; a home load beats a coincident encoder edge
    always_ff @(posedge sys_clk_in or negedge arst_n_in) begin
        if (!arst_n_in) begin
            count <= 32'h00000000;
        end else if (home_evt) begin
            count <= home_load_value;
        end else if (step) begin
            count <= up ? count + 32'h00000001 : count - 32'h00000001;
        end
    end

    // ********************************
    // Limit triggers and action output
    // ********************************
    // Edge detection keeps a parked counter from re-firing each cycle
    always_ff @(posedge sys_clk_in or negedge arst_n_in) begin
        if (!arst_n_in) begin
            hi_prev <= 1'b0;
            lo_prev <= 1'b0;
            action_out <= '0;
        end else begin
            hi_prev <= hi_cond;
            lo_prev <= lo_cond;
            // High limit wins if both limits fire together
            if (hi_rise && high_limit_action[3:0] != ELP_ACT_NONE) begin
                action_out <= {1'b1, high_limit_action[7:ACT_MOT_LSB],
                               high_limit_action[3:0]};
            end else if (lo_rise && low_limit_action[3:0] != ELP_ACT_NONE) begin
                action_out <= {1'b1, low_limit_action[7:ACT_MOT_LSB],
                               low_limit_action[3:0]};
            end else begin
                action_out <= '0;
            end
        end
    end

    // Sticky status, write one to clear; a new event beats the clear
    logic [ST_W-1:0] st_set, st_clr;
    assign st_set = {home_evt, lo_rise, hi_rise};
    assign st_clr = (wr_go && address_in == OFS_STATUS) ? writedata_in[ST_W-1:0] : '0;
    always_ff @(posedge sys_clk_in or negedge arst_n_in) begin
        if (!arst_n_in) begin
            status <= '0;
        end else begin
            status <= (status & ~st_clr) | st_set;
        end
    end
    assign irq_out = |(status & mask);

    // ********************************
    // Loop rate divider and PID
    // ********************************
    logic [15:0] div_cnt;
    logic tick;
    assign tick = div_cnt == 16'(LOOP_DIV - 1);
    always_ff @(posedge sys_clk_in or negedge arst_n_in) begin
        if (!arst_n_in) begin
            div_cnt <= 16'h0000;
        end else begin
            div_cnt <= tick ? 16'h0000 : div_cnt + 16'h0001;
        end
    end

    // Relative mode maps -1000..+1000 onto low..high limit
    logic signed [63:0] span, target, err, deriv, integ, next_integ, cap_lim, sum;
    logic signed [63:0] prev_err;
    assign span = 64'($signed(high_count_limit)) - 64'($signed(low_count_limit));
    assign target = ctrl[CTRL_REL_MODE] ? 64'($signed(low_count_limit))
        + ((64'($signed(pos_cmd)) + $signed(REL_HALF)) * span) / $signed(REL_SPAN)
        : 64'($signed(pos_cmd));
    assign err = target - 64'($signed(count));
    assign deriv = err - prev_err;
    assign cap_lim = $signed({32'h00000000, INT_FULL / 32'(CAP_MAX)})
        * $signed({56'h0, integral_cap});
    // Accumulator saturates at the cap in both directions
    always_comb begin
        next_integ = integ + err;
        if (next_integ > cap_lim) begin
            next_integ = cap_lim;
        end else if (next_integ < -cap_lim) begin
            next_integ = -cap_lim;
        end
    end
    // Fixed-point gains: products scaled down by one million
    assign sum = ($signed({32'h00000000, proportional_gain}) * err
        + $signed({32'h00000000, integral_gain}) * integ
        + $signed({32'h00000000, differential_gain}) * deriv) / $signed(GAIN_SCALE);

    // Loop state only advances while closed loop is enabled
    always_ff @(posedge sys_clk_in or negedge arst_n_in) begin
        if (!arst_n_in) begin
            integ <= 64'sh0;
            prev_err <= 64'sh0;
            loop_out <= 32'h00000000;
        end else if (tick) begin
            if (ctrl[CTRL_LOOP_EN] && !ctrl[CTRL_BL_TORQUE]) begin
                integ <= next_integ;
                prev_err <= err;
                loop_out <= sum[31:0];
            end else begin
                // Brushless torque uses the current loop, so hold zero here
                integ <= 64'sh0;
                prev_err <= 64'sh0;
                loop_out <= 32'h00000000;
            end
        end
    end

    // Speed as counts per loop tick, sign follows count direction
    always_ff @(posedge sys_clk_in or negedge arst_n_in) begin
        if (!arst_n_in) begin
            speed <= 32'h00000000;
            last_count <= 32'h00000000;
        end else if (tick) begin
            speed <= count - last_count;
            last_count <= count;
        end
    end

    // ********************************
    // Assertions
    // ********************************
    default clocking cb @(posedge sys_clk_in); endclocking
    default disable iff (!arst_n_in);
    a_home_load: assert property (home_evt |=> count == $past(home_load_value))
        else $error("home value not loaded");
    a_count_step: assert property (step && !home_evt && up |=> count == $past(count) + 1)
        else $error("count step wrong");
    a_count_inv: assert property (step && !home_evt && pulses_per_rev[15]
        && (sync2[0] ^ prev[1]) |=> count == $past(count) - 1)
        else $error("inverted count wrong");
    a_high_fire: assert property (hi_rise && high_limit_action[3:0] != 4'h0
        |=> action_out.valid && action_out.code == $past(high_limit_action[3:0]))
        else $error("high action missing");
    a_low_fire: assert property (lo_rise && !hi_rise && low_limit_action[3:0] != 4'h0
        |=> action_out.motors == $past(low_limit_action[7:4]))
        else $error("low action motors wrong");
    a_low_flag: assert property (lo_rise |=> status[ST_LOW])
        else $error("low flag not set");
    a_high_flag: assert property (hi_rise |=> status[ST_HIGH])
        else $error("high flag not set");
    a_home_flag: assert property (home_evt |=> status[ST_HOME])
        else $error("home flag not set");
    a_cap_range: assert property (integral_cap >= CAP_MIN && integral_cap <= CAP_MAX)
        else $error("cap out of range");
    a_integ_cap: assert property (tick |=> integ <= $past(cap_lim)
        && integ >= -$past(cap_lim))
        else $error("integral above cap");
    a_gain_range: assert property (proportional_gain <= GAIN_MAX
        && integral_gain <= GAIN_MAX && differential_gain <= GAIN_MAX)
        else $error("gain out of range");
    a_torque_zero: assert property (tick && ctrl[CTRL_BL_TORQUE] |=> loop_out == '0)
        else $error("torque mode output not zero");
    a_one_wait: assert property ((read_in || write_in) && waitrequest_out
        |=> !waitrequest_out)
        else $error("bus answer late");
    a_irq_follow: assert property ($rose(status[ST_HIGH]) && mask[ST_HIGH] |-> irq_out)
        else $error("irq not raised");
    c_high_hit: cover property (hi_rise ##1 action_out.valid);
    c_home_sw: cover property (home_sw_rise ##1 status[ST_HOME]);
    c_low_hit: cover property (lo_rise ##1 status[ST_LOW]);
    c_loop_run: cover property (tick && ctrl[CTRL_LOOP_EN] && err != 0);
endmodule
`default_nettype wire

// *** elp_enc_model.sv ***
// Purpose: Incremental quadrature encoder model on the motor shaft
// Assumes: Phases change just after a rising edge of the block clock
// Notes: Each phase edge is held five cycles, past the two-flop synchroniser
`timescale 1ns/1ns
`default_nettype none
module elp_enc_model (
    input wire logic sys_clk_in,
    output logic enc_a_out,
    output logic enc_b_out
);
    // ********************************
    // Phase sequencer
    // ********************************
    logic [1:0] ph = 2'h0;
    // Gray order 00 10 11 01, so A leads B when turning up
    assign enc_a_out = ph[1] ^ ph[0];
    assign enc_b_out = ph[1];
    // Four phase edges per pulse; slow hold so no edge is lost in sync
    task automatic spin(input int n, input logic up);
        int i;
        for (i = 0; i < 4 * n; i++) begin
            @(posedge sys_clk_in);
            ph <= up ? ph + 2'h1 : ph - 2'h1;
            repeat (4) @(posedge sys_clk_in);
        end
    endtask
endmodule
`default_nettype wire

// *** elp_tb.sv ***
// Purpose: Self-checking bench for the encoder limit and PID block
// Assumes: One wait state per bus access, loop tick every four cycles
// Notes: Loop error taken as target minus count
`timescale 1ns/1ns
`default_nettype none
module testbench;
    import elp_pkg::*;
    // ********************************
    // Signals and instances
    // ********************************
    logic sys_clk = 1'b0;
    logic arst_n = 1'b0;
    logic [6:0] address = 7'h00;
    logic read = 1'b0;
    logic write = 1'b0;
    logic [31:0] wdata = 32'h0;
    logic [31:0] rdata;
    logic waitreq;
    logic enc_a;
    logic enc_b;
    logic home_sw = 1'b0;
    logic script_home = 1'b0;
    elp_action_t action;
    elp_action_t last_act = '0;
    logic [7:0] usage;
    logic [31:0] loop_val;
    logic irq;
    logic [31:0] d;
    int fails = 0;
    int checks = 0;
    always #20 sys_clk = ~sys_clk;
    elp_core #(.LOOP_DIV(4)) dut (.sys_clk_in(sys_clk), .arst_n_in(arst_n),
        .address_in(address), .read_in(read), .write_in(write),
        .writedata_in(wdata), .readdata_out(rdata), .waitrequest_out(waitreq),
        .enc_a_in(enc_a), .enc_b_in(enc_b), .home_sw_in(home_sw),
        .script_home_in(script_home), .action_out(action), .usage_out(usage),
        .loop_out(loop_val), .irq_out(irq));
    elp_enc_model enc (.sys_clk_in(sys_clk), .enc_a_out(enc_a), .enc_b_out(enc_b));
    // Latch each action pulse, it only stands one cycle
    always @(posedge sys_clk) if (action.valid === 1'b1) last_act <= action;
    // ********************************
    // Shared tasks
    // ********************************
    task automatic finish_test();
        $display("checks %0d fails %0d", checks, fails);
        if (fails == 0 && checks > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        checks++;
        if (got !== exp) begin
            fails++;
            $display("wrong value at %0t got %h expected %h", $time, got, exp);
        end
    endtask
    // Request held until waitrequest is sampled low; bounded wait
    task automatic bus(input logic wr, input logic [6:0] a, input logic [31:0] wd);
        int n;
        @(posedge sys_clk);
        address <= a;
        write <= wr;
        read <= ~wr;
        wdata <= wd;
        for (n = 0; n < 16; n++) begin
            @(posedge sys_clk);
            if (waitreq === 1'b0) break;
        end
        d = rdata;
        read <= 1'b0;
        write <= 1'b0;
        if (n == 16) begin
            fails++;
            finish_test();
        end
    endtask
    task automatic rd_chk(input logic [6:0] a, input logic [31:0] exp);
        bus(1'b0, a, 32'h0);
        chk(d, exp);
    endtask
    // Outputs looked at mid-cycle, after the edge has settled
    // Selector, not value, is passed so the output is read after the wait
    task automatic out_chk(input logic [1:0] sel, input logic [31:0] exp);
        @(negedge sys_clk);
        case (sel)
            2'h0: chk({24'h0, usage}, exp);
            2'h1: chk({31'h0, irq}, exp);
            default: chk(loop_val, exp);
        endcase
    endtask
    // ********************************
    // Scenarios
    // ********************************
    task automatic t_reset();
        rd_chk(OFS_HIGH_LIMIT, 32'h00004E20);
        rd_chk(OFS_LOW_LIMIT, 32'hFFFFB1E0);
        rd_chk(OFS_PULSES, 32'h00000064);
        rd_chk(OFS_INT_CAP, 32'h00000064);
        rd_chk(OFS_PROP_GAIN, 32'h0);
        rd_chk(OFS_INT_GAIN, 32'h0);
        rd_chk(OFS_DIFF_GAIN, 32'h0);
        rd_chk(OFS_HIGH_ACTION, 32'h0);
        rd_chk(OFS_LOW_ACTION, 32'h0);
        bus(1'b1, 7'h48, 32'hA5A5A5A5);
        rd_chk(7'h48, 32'h0);
        bus(1'b1, OFS_USAGE, 32'h12);
        out_chk(2'h0, 32'h12);
        $display("test reset and usage done");
    endtask
    task automatic t_count();
        enc.spin(5, 1'b1);
        rd_chk(OFS_COUNT, 32'h14);
        bus(1'b1, OFS_PULSES, 32'hFFFFFF9C);
        rd_chk(OFS_PULSES, 32'hFFFFFF9C);
        enc.spin(2, 1'b1);
        rd_chk(OFS_COUNT, 32'hC);
        bus(1'b1, OFS_PULSES, 32'h64);
        $display("test counting done");
    endtask
    task automatic t_home();
        bus(1'b1, OFS_HOME, 32'h100);
        bus(1'b1, OFS_CTRL, 32'h2);
        rd_chk(OFS_COUNT, 32'h100);
        enc.spin(1, 1'b1);
        home_sw <= 1'b1;
        repeat (6) @(posedge sys_clk);
        home_sw <= 1'b0;
        rd_chk(OFS_COUNT, 32'h100);
        enc.spin(1, 1'b1);
        script_home <= 1'b1;
        @(posedge sys_clk) script_home <= 1'b0;
        rd_chk(OFS_COUNT, 32'h100);
        rd_chk(OFS_STATUS, 32'h4);
        bus(1'b1, OFS_STATUS, 32'h4);
        $display("test home load done");
    endtask
    // Action codes 1..8, motor term rotating over 16, 32, 48
    task automatic t_limits();
        int c;
        logic [7:0] act;
        bus(1'b1, OFS_HIGH_LIMIT, 32'h103);
        bus(1'b1, OFS_MASK, 32'h1);
        // Pulse comes on the edge the spin returns at; latch takes it one edge later
        for (c = 1; c <= 8; c++) begin
            act = 8'((c % 3 + 1) * 16 + c);
            bus(1'b1, OFS_HIGH_ACTION, {24'h0, act});
            enc.spin(1, 1'b1);
            repeat (2) @(posedge sys_clk);
            chk({24'h0, last_act.motors, last_act.code}, {24'h0, act});
            if (c != 8) enc.spin(1, 1'b0);
        end
        rd_chk(OFS_COUNT, 32'h100);
        out_chk(2'h1, 32'h1);
        bus(1'b1, OFS_MASK, 32'h0);
        out_chk(2'h1, 32'h0);
        bus(1'b1, OFS_MASK, 32'h3);
        bus(1'b1, OFS_STATUS, 32'h5);
        out_chk(2'h1, 32'h0);
        bus(1'b1, OFS_LOW_LIMIT, 32'hFD);
        bus(1'b1, OFS_LOW_ACTION, 32'h30);
        enc.spin(1, 1'b0);
        repeat (2) @(posedge sys_clk);
        chk({24'h0, last_act.motors, last_act.code}, 32'h38);
        rd_chk(OFS_STATUS, 32'h2);
        out_chk(2'h1, 32'h1);
        bus(1'b1, OFS_LOW_ACTION, 32'h25);
        enc.spin(1, 1'b1);
        enc.spin(1, 1'b0);
        repeat (2) @(posedge sys_clk);
        chk({24'h0, last_act.motors, last_act.code}, 32'h25);
        $display("test limit actions done");
    endtask
    task automatic t_pid();
        bus(1'b1, OFS_INT_CAP, 32'h0);
        rd_chk(OFS_INT_CAP, 32'h1);
        bus(1'b1, OFS_INT_CAP, 32'h100);
        rd_chk(OFS_INT_CAP, 32'h64);
        bus(1'b1, OFS_INT_CAP, 32'hC8);
        rd_chk(OFS_INT_CAP, 32'h64);
        bus(1'b1, OFS_DIFF_GAIN, 32'hFFFFFFFF);
        rd_chk(OFS_DIFF_GAIN, 32'h77359400);
        bus(1'b1, OFS_DIFF_GAIN, 32'h0);
        bus(1'b1, OFS_PROP_GAIN, 32'h001E8480);
        bus(1'b1, OFS_HOME, 32'h0);
        bus(1'b1, OFS_CTRL, 32'h2);
        bus(1'b1, OFS_HIGH_LIMIT, 32'h7D0);
        bus(1'b1, OFS_LOW_LIMIT, 32'hFFFFF830);
        bus(1'b1, OFS_POS_CMD, 32'h64);
        bus(1'b1, OFS_CTRL, 32'h1);
        repeat (12) @(posedge sys_clk);
        out_chk(2'h2, 32'hC8);
        bus(1'b1, OFS_POS_CMD, 32'hFFFFFC18);
        bus(1'b1, OFS_CTRL, 32'h5);
        repeat (12) @(posedge sys_clk);
        out_chk(2'h2, 32'hFFFFF060);
        bus(1'b1, OFS_POS_CMD, 32'h3E8);
        repeat (12) @(posedge sys_clk);
        out_chk(2'h2, 32'hFA0);
        bus(1'b1, OFS_CTRL, 32'hD);
        repeat (12) @(posedge sys_clk);
        out_chk(2'h2, 32'h0);
        $display("test loop gains done");
    endtask
    // ********************************
    // Main sequence and watchdog
    // ********************************
    initial begin
        repeat (8) @(posedge sys_clk);
        arst_n <= 1'b1;
        t_reset();
        t_count();
        t_home();
        t_limits();
        t_pid();
        finish_test();
    end
    // Cuts a hang short well inside the cycle budget
    initial begin
        repeat (30000) @(posedge sys_clk);
        fails++;
        finish_test();
    end
endmodule
`default_nettype wire
